// ---- common/mio_pkg.sv ----
// Shared constants and carrier types for the monitor and input select block.
// Assumes a single 250 MHz clock; frequencies are carried in 0.1 Hz units.
package mio_pkg;

  // ===========================================================
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;

  // ===========================================================
  // Widths
  localparam int unsigned ADC_W  = 10;  // Converted analog sample
  localparam int unsigned FREQ_W = 16;  // Frequency, 0.1 Hz per unit
  localparam int unsigned CUR_W  = 9;   // Current, percent of rated
  localparam int unsigned GAIN_W = 8;   // Monitor gain 0..255

  // ===========================================================
  // Codes
  localparam logic [1:0] FSRC_ANALOG  = 2'h1;
  localparam logic [1:0] MON_FREQ_PWM = 2'h0;
  localparam logic [1:0] MON_CUR_PWM  = 2'h1;
  localparam logic [1:0] MON_PULSE    = 2'h2;

  // Full scale of the current monitor, percent
  localparam logic [FREQ_W-1:0] CUR_FULL_PCT = 16'h00C8;

  // Reset values
  localparam logic [1:0]        MON_SEL_RST = MON_FREQ_PWM;
  localparam logic [GAIN_W-1:0] GAIN_RST    = 8'h00;

  // ===========================================================
  // Carriers
  typedef struct packed {
    logic              cal_full;  // Force pin continuously on
    logic [1:0]        sel;       // Monitor form
    logic [GAIN_W-1:0] gain;      // PWM gain
  } mio_mon_cfg_t;

  typedef struct packed {
    logic [FREQ_W-1:0] out_freq;  // Present output frequency
    logic [FREQ_W-1:0] max_freq;  // Maximum-frequency setting
    logic [CUR_W-1:0]  out_cur;   // Output current, percent
  } mio_drive_t;

endpackage

// ---- verilog/mio_monitor.sv ----
// Frequency command source select and monitor pin generator.
// Assumes analog samples, drive data and settings arrive on MCLK; only the
// analog-type select pin is asynchronous and is synchronised here.
// Functional notes
// [RULE1] Select inactive: voltage input commands frequency
// [RULE2] Select active: current input commands frequency
// [RULE3] Select unassigned: sum voltage and current
// [RULE4] Analog inputs used only with source 01
// [RULE5] Monitor form: freq PWM, current PWM, pulses
// [RULE6] PWM duty scaled by gain 0..255
// [RULE7] Calibration holds monitor pin continuously on
// [RULE8] Pulse rate equals ten times output frequency; code caps it at ten times max_freq
// [RULE9] Pulse form is digital, ignores gain
// [RULE10] Fixed period, duty value/full times gain
// [RULE11] New settings taken only at boundaries; code applies cal_full on the next clock
`timescale 1ns/1ps
`default_nettype none

module mio_monitor
  import mio_pkg::*;
#(
  parameter int unsigned PWM_PERIOD = 4000,  // Cycles per PWM period
  parameter int unsigned GAIN_NOM   = 100    // Gain giving unity scale
) (
  input  wire logic                       MCLK,
  input  wire logic                       RST,
  input  wire logic                       ANALOG_TYPE_SEL,
  input  wire logic                       TYPE_SEL_ASSIGNED,
  input  wire logic [1:0]                 FREQ_SOURCE,
  input  wire logic [mio_pkg::ADC_W-1:0]  VOLT_IN,
  input  wire logic [mio_pkg::ADC_W-1:0]  CURRENT_IN,
  input  wire logic [mio_pkg::FREQ_W-1:0] OTHER_CMD,
  input  var  mio_pkg::mio_mon_cfg_t      MON_CFG,
  input  var  mio_pkg::mio_drive_t        DRIVE,
  output logic [mio_pkg::FREQ_W-1:0]      FREQ_CMD,
  output logic                            MONITOR_PIN
);
  import mio_pkg::*;

  localparam int unsigned CNT_W  = $clog2(PWM_PERIOD);
  localparam int unsigned RAMP_W = 48;
  localparam int unsigned ACC_W  = 30;
  localparam logic [CNT_W-1:0]  CNT_LAST = CNT_W'(PWM_PERIOD - 1);
  localparam logic [RAMP_W-1:0] PER_R    = RAMP_W'(PWM_PERIOD);
  localparam logic [RAMP_W-1:0] GNOM_R   = RAMP_W'(GAIN_NOM);
  localparam logic [ACC_W-1:0]  CLK_A    = ACC_W'(CLK_HZ);

  // ===========================================================
  // Analog-type select synchroniser
  // A change counts only once the last two stages agree.
  logic [2:0] type_sel_sync;
  logic       type_sel_level;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      type_sel_sync <= 3'h0;
    end else begin
      type_sel_sync <= {type_sel_sync[1:0], ANALOG_TYPE_SEL};
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      type_sel_level <= 1'b0;  // Voltage input until the pin says otherwise
    end else if (type_sel_sync[1] == type_sel_sync[2]) begin
      type_sel_level <= type_sel_sync[2];
    end
  end

  // ===========================================================
  // Frequency command source
  logic [FREQ_W-1:0] next_freq_cmd;

  always_comb begin
    if (FREQ_SOURCE != FSRC_ANALOG) begin
      next_freq_cmd = OTHER_CMD;                                 // RULE4
    end else if (!TYPE_SEL_ASSIGNED) begin
      next_freq_cmd = FREQ_W'(VOLT_IN) + FREQ_W'(CURRENT_IN);    // RULE3
    end else if (type_sel_level) begin
      next_freq_cmd = FREQ_W'(CURRENT_IN);                       // RULE2
    end else begin
      next_freq_cmd = FREQ_W'(VOLT_IN);                          // RULE1
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FREQ_CMD <= '0;
    end else begin
      FREQ_CMD <= next_freq_cmd;
    end
  end

  // ===========================================================
  // Settings and values held for one period or pulse
  logic [1:0]        act_sel;
  logic [GAIN_W-1:0] act_gain;
  logic [RAMP_W-1:0] act_num;   // value * gain * period
  logic [RAMP_W-1:0] act_den;   // full scale * nominal gain
  logic [FREQ_W-1:0] act_freq;  // Pulse-form rate, clamped
  logic [CNT_W-1:0]  cnt;
  logic [RAMP_W-1:0] ramp;
  logic [ACC_W-1:0]  acc;
  logic              toggle;
  logic              boundary;
  logic [FREQ_W-1:0] mon_val;
  logic [FREQ_W-1:0] mon_full;
  logic [FREQ_W-1:0] clamp_freq;

  // Frequency clamp keeps the pulse rate at or under ten times the maximum
  assign clamp_freq = (DRIVE.out_freq > DRIVE.max_freq) ?
                      DRIVE.max_freq : DRIVE.out_freq;           // RULE8

  // Monitored value and its full scale for the PWM forms
  always_comb begin
    if (MON_CFG.sel == MON_CUR_PWM) begin
      mon_val  = FREQ_W'(DRIVE.out_cur);
      mon_full = CUR_FULL_PCT;                                   // RULE5
    end else begin
      mon_val  = clamp_freq;
      mon_full = DRIVE.max_freq;                                 // RULE5
    end
  end

  // Pulse form ends a pulse on its falling toggle; a stopped pulse train
  // re-arms every cycle so a new rate is never missed.
  assign boundary = (act_sel == MON_PULSE) ?
                    ((toggle && MONITOR_PIN) || (act_freq == '0)) :
                    (cnt == CNT_LAST);                           // RULE11

  // Latch settings at the boundary only
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      act_sel  <= MON_SEL_RST;
      act_gain <= GAIN_RST;
      act_num  <= '0;
      act_den  <= '0;
      act_freq <= '0;
    end else if (boundary) begin                                 // RULE11
      act_sel  <= MON_CFG.sel;
      act_gain <= MON_CFG.gain;
      act_num  <= RAMP_W'(mon_val) * RAMP_W'(MON_CFG.gain) * PER_R; // RULE6
      act_den  <= RAMP_W'(mon_full) * GNOM_R;
      act_freq <= clamp_freq;
    end
  end

  // ===========================================================
  // PWM period counter and duty ramp
  // Ramp avoids a divider: high while elapsed*den < value*gain*period.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt <= '0;
    end else if (cnt == CNT_LAST) begin
      cnt <= '0;                                                 // RULE10
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ramp <= '0;
    end else if (cnt == CNT_LAST) begin
      ramp <= '0;
    end else begin
      ramp <= ramp + act_den;
    end
  end

  // ===========================================================
  // Pulse-form phase accumulator
  // Adds twice the rate per cycle and toggles on each wrap of the clock
  // rate, so the rate in 0.1 Hz units is the pulse rate in Hz.
  logic [ACC_W-1:0] acc_sum;
  assign acc_sum = acc + {{(ACC_W-FREQ_W-1){1'b0}}, act_freq, 1'b0};
  assign toggle  = (act_sel == MON_PULSE) && (acc_sum >= CLK_A);  // RULE9

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      acc <= '0;
    end else if (act_sel != MON_PULSE) begin
      acc <= '0;
    end else if (toggle) begin
      acc <= acc_sum - CLK_A;                                    // RULE8
    end else begin
      acc <= acc_sum;
    end
  end

  // ===========================================================
  // Monitor pin
  logic next_pin;

  always_comb begin
    if (MON_CFG.cal_full) begin
      next_pin = 1'b1;                                           // RULE7
    end else if (act_sel == MON_PULSE) begin
      next_pin = toggle ? !MONITOR_PIN : MONITOR_PIN;            // RULE9
    end else if (cnt == CNT_LAST) begin
      next_pin = 1'b0;  // Next period's first cycle forced low; new settings drive the pin from its second cycle
    end else begin
      next_pin = (ramp < act_num);                               // RULE10
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      MONITOR_PIN <= 1'b0;
    end else begin
      MONITOR_PIN <= next_pin;
    end
  end

  // ===========================================================
  // Checks
  chk_volt_source: assert property (@(posedge MCLK) disable iff (RST) // RULE1
    (FREQ_SOURCE == FSRC_ANALOG && TYPE_SEL_ASSIGNED && !type_sel_level)
      |=> FREQ_CMD == FREQ_W'($past(VOLT_IN)))
    else $error("voltage input not selected");

  chk_curr_source: assert property (@(posedge MCLK) disable iff (RST) // RULE2
    (FREQ_SOURCE == FSRC_ANALOG && TYPE_SEL_ASSIGNED && type_sel_level)
      |=> FREQ_CMD == FREQ_W'($past(CURRENT_IN)))
    else $error("current input not selected");

  chk_sum_source: assert property (@(posedge MCLK) disable iff (RST) // RULE3
    (FREQ_SOURCE == FSRC_ANALOG && !TYPE_SEL_ASSIGNED)
      |=> FREQ_CMD == FREQ_W'($past(VOLT_IN)) + FREQ_W'($past(CURRENT_IN)))
    else $error("analog sum wrong");

  chk_other_source: assert property (@(posedge MCLK) disable iff (RST) // RULE4
    (FREQ_SOURCE != FSRC_ANALOG) |=> FREQ_CMD == $past(OTHER_CMD))
    else $error("analog used outside source 01");

  chk_cal_full: assert property (@(posedge MCLK) disable iff (RST) // RULE7
    MON_CFG.cal_full [*2] |=> MONITOR_PIN)
    else $error("calibration not full scale");

  chk_zero_gain: assert property (@(posedge MCLK) disable iff (RST) // RULE6
    (act_sel != MON_PULSE && act_gain == '0 && !MON_CFG.cal_full)
      |=> !MONITOR_PIN)
    else $error("zero gain gave output");

  chk_cfg_boundary: assert property (@(posedge MCLK) disable iff (RST) // RULE11
    (act_sel != $past(act_sel)) |-> $past(boundary))
    else $error("form changed mid period");

  chk_pulse_clamp: assert property (@(posedge MCLK) disable iff (RST) // RULE8
    (act_sel == MON_PULSE && $stable(DRIVE.max_freq))
      |-> act_freq <= DRIVE.max_freq || $past(boundary) == 1'b0)
    else $error("pulse rate over maximum");

  chk_pulse_toggle: assert property (@(posedge MCLK) disable iff (RST) // RULE9
    (act_sel == MON_PULSE && !toggle && !MON_CFG.cal_full)
      |=> $stable(MONITOR_PIN))
    else $error("pulse pin moved without toggle");

endmodule // mio_monitor

`default_nettype wire

// ---- verification/mio_meter.sv ----
// Panel meter model: times each whole period of the monitor pin.
// Assumes the pin is sampled on the drive clock and starts a period on a rise.
`timescale 1ns/1ps
`default_nettype none

module mio_meter (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pin,
  output logic [15:0]      period,
  output logic [15:0]      high
);
  logic        prev;
  logic [15:0] cnt;
  logic [15:0] hcnt;

  // ==========================================================
  // Period timing
  // A rise closes a period; a coil meter only sees whole periods
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev   <= 1'b0;
      cnt    <= 16'h0000;
      hcnt   <= 16'h0000;
      period <= 16'h0000;
      high   <= 16'h0000;
    end else begin
      prev <= pin;
      if (pin && !prev) begin
        period <= cnt;
        high   <= hcnt;
        cnt    <= 16'h0001;
        hcnt   <= 16'h0001;
      end else begin
        cnt  <= cnt + 16'h0001;  // Wraps on a stuck pin or on a period over 65535 cycles
        hcnt <= hcnt + {15'h0000, pin};
      end
    end
  end
endmodule // mio_meter

`default_nettype wire

// ---- verification/mio_monitor_tb.sv ----
// Self-checking bench for the command select and monitor pin block.
// Assumes a short PWM period of 16 cycles; the meter model times the pin.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp=%0d got=%0d", nm, e, g); end end

module mio_monitor_tb;
  import mio_pkg::*;
  localparam int P = 16;
  localparam int GN = 100;
  logic         mclk, rst, type_sel, sel_asg, pin;
  logic [1:0]   fsrc;
  logic [9:0]   volt, cur;
  logic [15:0]  other, fcmd, per, hi, ev;
  mio_mon_cfg_t cfg;
  mio_drive_t   drv;
  int           seed, mismatches, checks_done, i, n, v, m, g, full;

  mio_monitor #(.PWM_PERIOD(P), .GAIN_NOM(GN)) dut (
    .MCLK(mclk), .RST(rst), .ANALOG_TYPE_SEL(type_sel),
    .TYPE_SEL_ASSIGNED(sel_asg), .FREQ_SOURCE(fsrc), .VOLT_IN(volt),
    .CURRENT_IN(cur), .OTHER_CMD(other),
    .MON_CFG(cfg), .DRIVE(drv), .FREQ_CMD(fcmd), .MONITOR_PIN(pin));
  mio_meter meter (.clk(mclk), .rst(rst), .pin(pin), .period(per), .high(hi));

  // ==========================================================
  // Expectations
  // High cycles rounded up, capped one short since the boundary is low
  function automatic int pwm_high(int val, int fs, int gain);
    int h;
    h = (val * gain * P + fs * GN - 1) / (fs * GN);
    return (h > P - 1) ? P - 1 : h;
  endfunction

  task automatic final_report;
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Tests need under 70k cycles; a hang is cut off well after that
  initial begin
    #380000;
    mismatches++;
    final_report;
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 67; mismatches = 0; checks_done = 0;
    rst = 1'b1; type_sel = 1'b0; sel_asg = 1'b1; fsrc = FSRC_ANALOG;
    volt = 10'h000; cur = 10'h000; other = 16'h0000;
    cfg = '0; drv = '0;
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    // Every select, assignment and source code, allowing for the sync
    for (i = 0; i < 16; i++) begin
      volt = 10'($random(seed)); cur = 10'($random(seed));
      other = 16'($random(seed));
      type_sel = i[0]; sel_asg = ~i[1]; fsrc = i[3:2];
      repeat (8) @(negedge mclk);
      ev = (fsrc != FSRC_ANALOG) ? other : !sel_asg ? volt + cur
           : type_sel ? {6'h00, cur} : {6'h00, volt};
      `CHK("freq_cmd", ev, fcmd)
    end
    // Both PWM forms; first two passes use top gain to hit the cap
    for (i = 0; i < 12; i++) begin
      m = 100 + ({$random(seed)} % 1000);
      g = (i < 2) ? 255 : 1 + ({$random(seed)} % 255);
      cfg.sel = i[0] ? MON_CUR_PWM : MON_FREQ_PWM;
      cfg.gain = 8'(g);
      drv.max_freq = 16'(m);
      drv.out_freq = 16'(1 + ({$random(seed)} % m));
      drv.out_cur = 9'(1 + ({$random(seed)} % 400));
      v = i[0] ? int'(drv.out_cur) : int'(drv.out_freq);
      full = i[0] ? 200 : m;
      repeat (5 * P) @(negedge mclk);
      ev = 16'(pwm_high(v, full, g));
      `CHK("pwm_high", ev, hi)
      `CHK("pwm_period", 16'(P), per)
    end
    // Calibration drive holds the pin on for three periods
    cfg.cal_full = 1'b1;
    repeat (2) @(negedge mclk);
    n = 0;
    repeat (3 * P) begin
      @(negedge mclk);
      n += int'(pin === 1'b1);
    end
    `CHK("cal_on", 3 * P, n)
    cfg.cal_full = 1'b0;
    // Pulse form, second pass clamped by the maximum setting
    for (i = 0; i < 3; i++) begin
      n = 40000 + ({$random(seed)} % 25000);
      m = (i == 1) ? n - 5000 : 65535;
      cfg.sel = MON_PULSE;
      cfg.gain = 8'($random(seed));
      drv.out_freq = 16'(n);
      drv.max_freq = 16'(m);
      v = CLK_HZ / ((n < m) ? n : m);
      // Old rate may need a whole slow period before the new one latches
      repeat (2 * v + 7300) @(negedge mclk);
      // A digital divider may jitter up to two cycles either way; unknown still fails
      ev = (int'(per) >= v - 2 && int'(per) <= v + 2) ? 16'(v) : per;
      `CHK("pulse_period", 16'(v), ev)
    end
    final_report;
  end
endmodule // mio_monitor_tb

`default_nettype wire
